// [verification/gpti_bench.sv]
// Self-checking bench for the IEEE-488 device interface
`timescale 1ns/1ns
module gpti_bench;
   import gpti_pkg::*;
   logic          clk, arst_n, addr_load, tx_valid, tx_ready, rx_valid;
   logic          srq_req, trigger, dev_clear;
   logic [5:0]    addr_set;
   logic [7:0]    status_byte;
   gpti_bus_in_t  bus_in;
   gpti_bus_out_t bus_out;
   gpti_word_t    tx_word, rx_word, last_rx;
   gpti_state_t   state;
   int            miscompares, n_tests, n_rx, n_trig, n_clr, cyc, i;
   // Command byte beside expected {remote, lockout, talker, listener}
   logic [11:0]   rows [14] = '{12'h250, 12'h3b9, 12'h5ba, 12'h7ba, 12'h3b9,
      12'h3f8, 12'h5ba, 12'h458, 12'h5ba, 12'h5f8, 12'h3b9, 12'h011, 12'h115, 12'h3bd};

   gpti_top DUT (.CLK(clk), .ARST_N(arst_n), .BUS_IN(bus_in), .BUS_OUT(bus_out),
      .ADDR_SET(addr_set), .ADDR_LOAD(addr_load), .TX_VALID(tx_valid),
      .TX_WORD(tx_word), .TX_READY(tx_ready), .RX_VALID(rx_valid), .RX_WORD(rx_word),
      .STATUS_BYTE(status_byte), .SRQ_REQ(srq_req), .TRIGGER(trigger),
      .DEV_CLEAR(dev_clear), .STATE(state));
   gpti_ctrl_model ctrl (.clk(clk), .dev(bus_out), .bus(bus_in));

   // ========================
   // Helpers
   task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   task automatic cmd(input logic [6:0] c);
      ctrl.send({1'b0, c}, 1'b1, 1'b0);
      repeat (4) @(posedge clk);
   endtask
   // Push one word; ready drops the cycle after each push, so wait for ready
   task automatic push(input logic [8:0] w);
      int n = 0;
      do @(posedge clk); while (tx_ready !== 1'b1 && ++n < 200);
      #1 tx_valid = 1'b1;
      tx_word = w;
      @(posedge clk);
      #1 tx_valid = 1'b0;
   endtask
   task automatic wait_got(input int k);
      int n = 0;
      while (ctrl.n_got < k && n < 2000) begin @(posedge clk); n++; end
   endtask
   task automatic load(input logic [5:0] a);
      @(posedge clk);
      #1 addr_set = a;
      addr_load = 1'b1;
      @(posedge clk);
      #1 addr_load = 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Free-running clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Pulse counters and the hang ceiling
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (rx_valid === 1'b1) n_rx <= n_rx + 1;
      if (rx_valid === 1'b1) last_rx <= rx_word;
      if (trigger === 1'b1) n_trig <= n_trig + 1;
      if (dev_clear === 1'b1) n_clr <= n_clr + 1;
      if (cyc == 30000)
      begin
         miscompares++;
         summarize();
      end
   end

   // ========================
   // Main sequence
   initial
   begin
      arst_n = 1'b0;
      addr_set = 6'h00;
      addr_load = 1'b0;
      tx_valid = 1'b0;
      tx_word = '0;
      status_byte = 8'h00;
      srq_req = 1'b0;
      repeat (4) @(posedge clk);
      #1 arst_n = 1'b1;
      repeat (3) @(posedge clk);
      check("outputs after reset", {bus_out, state}, 20'h0);
      done("reset");
      #1 ctrl.ren = 1'b1;
      for (i = 0; i < 14; i++)
      begin
         ctrl.send(rows[i][11:4], 1'b1, 1'b0);
         repeat (4) @(posedge clk);
         check("state after command", state[6:3], rows[i][3:0]);
      end
      done("command table");
      ctrl.send(8'ha5, 1'b0, 1'b1);
      repeat (4) @(posedge clk);
      check("received word", {n_rx[3:0], last_rx}, {4'h1, 9'h1a5});
      cmd(GPTI_CMD_GET);
      cmd(GPTI_CMD_SDC);
      cmd(GPTI_CMD_DCL);
      cmd(GPTI_CMD_UNL);
      cmd(GPTI_CMD_GET);
      ctrl.send(8'h5a, 1'b0, 1'b0);
      repeat (4) @(posedge clk);
      check("trigger clear data counts", {n_trig[3:0], n_clr[3:0], n_rx[3:0]}, 12'h121);
      done("listener");
      cmd(7'h5b);
      #1 ctrl.c_atn = 1'b0;
      ctrl.slow = 1'b1;
      push(9'h03c);
      push(9'h1c3);
      wait_got(1);
      check("first sourced byte", ctrl.got, 9'h03c);
      wait_got(2);
      check("last sourced byte", ctrl.got, 9'h1c3);
      ctrl.slow = 1'b0;
      cmd(GPTI_CMD_UNT);
      done("talker");
      #1 srq_req = 1'b1;
      status_byte = 8'h05;
      repeat (6) @(posedge clk);
      check("service request line", bus_out.srq_oe, 1'b1);
      cmd(GPTI_CMD_SPE);
      cmd(7'h5b);
      #1 ctrl.c_atn = 1'b0;
      wait_got(3);
      check("polled status byte", ctrl.got[7:0], 8'h45);
      repeat (8) @(posedge clk);
      #1 srq_req = 1'b0;
      cmd(GPTI_CMD_SPD);
      cmd(GPTI_CMD_UNT);
      done("serial poll");
      #1 ctrl.c_atn = 1'b1;
      ctrl.c_eoi = 1'b1;
      repeat (8) @(posedge clk);
      check("data lines in poll", bus_out.dio_oe, 8'h00);
      #1 ctrl.c_eoi = 1'b0;
      cmd(7'h3b);
      #1 ctrl.ifc = 1'b1;
      repeat (10) @(posedge clk);
      #1 ctrl.ifc = 1'b0;
      check("idle after interface clear", state[4:3], 2'b00);
      ctrl.ren = 1'b0;
      repeat (6) @(posedge clk);
      check("local after enable drop", state[6:5], 2'b00);
      done("clear and local");
      load(6'h05);
      load(6'h1f);
      cmd(7'h25);
      check("listen at new address", state.listener, 1'b1);
      cmd(GPTI_CMD_UNL);
      load(6'h28);
      cmd(7'h25);
      check("talk-only with prefix", {state.listener, state[2:0]}, 4'b0011);
      #1 ctrl.c_atn = 1'b0;
      push(9'h15a);
      wait_got(4);
      check("talk-only byte", ctrl.got, 9'h15a);
      load(6'h29);
      check("talk-only without prefix", state[1:0], 2'b10);
      done("addressing");
      summarize();
   end
endmodule

// [verification/gpti_chk_sva.sv]
// Port-level assertion checker for the IEEE-488 device interface
`timescale 1ns/1ns
module gpti_chk
(
   input wire logic               CLK,
   input wire logic               ARST_N,
   input gpti_pkg::gpti_bus_in_t  BUS_IN,
   input gpti_pkg::gpti_bus_out_t BUS_OUT,
   input wire logic               SRQ_REQ,
   input wire logic               RX_VALID,
   input wire logic               TRIGGER,
   input gpti_pkg::gpti_state_t   STATE
);
   import gpti_pkg::*;
   // ========================
   // Single domain, async reset
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   // ========================
   // Source side
   a_src_needs_addr: assert property (
      BUS_OUT.dav_oe |-> STATE.talker || STATE.talk_only)
      else $error("data valid driven while not a talker");
   a_dav_holds_data: assert property (
      BUS_OUT.dav_oe && $past(BUS_OUT.dav_oe) |-> $stable(BUS_OUT.dio_oe))
      else $error("data lines moved under data valid");
   a_dav_waits_accept: assert property (
      BUS_OUT.dav_oe && BUS_IN.ndac && !BUS_IN.atn && !BUS_IN.ifc |=> BUS_OUT.dav_oe)
      else $error("data valid dropped before acceptance");
   a_dav_after_ready: assert property (
      $rose(BUS_OUT.dav_oe) |-> !$past(BUS_IN.nrfd, 2))
      else $error("data valid raised while listeners not ready");
   // Poll fires only with attention and end held long enough to abort a source
   a_no_ppoll_drive: assert property (
      (BUS_IN.atn && BUS_IN.eoi) [*4] |-> BUS_OUT.dio_oe == 8'h00)
      else $error("data line driven during parallel poll");
   // ========================
   // Acceptor side and state
   a_rx_when_listen: assert property (
      RX_VALID |-> STATE.listener)
      else $error("data received while not a listener");
   a_trig_when_listen: assert property (
      TRIGGER |-> STATE.listener)
      else $error("trigger while not a listener");
   a_talk_listen_excl: assert property (
      !(STATE.talker && STATE.listener))
      else $error("talker and listener at once");
   a_srq_follows_req: assert property (
      $rose(SRQ_REQ) |-> ##[1:4] BUS_OUT.srq_oe)
      else $error("service request line not raised");
   a_local_on_ren_low: assert property (
      !BUS_IN.ren [*5] |-> !STATE.remote && !STATE.lockout)
      else $error("remote or lockout kept without remote enable");
   a_remote_with_listen: assert property (
      $rose(STATE.remote) |-> ##[0:1] (STATE.listener && BUS_IN.ren))
      else $error("remote entered without listen address");
   a_to_no_listen: assert property (
      STATE.talk_only |-> !STATE.listener)
      else $error("listener in talk-only mode");
endmodule

bind gpti_top gpti_chk u_chk (.CLK(CLK), .ARST_N(ARST_N), .BUS_IN(BUS_IN),
   .BUS_OUT(BUS_OUT), .SRQ_REQ(SRQ_REQ), .RX_VALID(RX_VALID), .TRIGGER(TRIGGER),
   .STATE(STATE));

// [verification/gpti_ctrl_model.sv]
// Bus controller and listening instrument facing the device
`timescale 1ns/1ns
module gpti_ctrl_model
(
   input wire logic                clk,
   input gpti_pkg::gpti_bus_out_t  dev,
   output gpti_pkg::gpti_bus_in_t  bus
);
   import gpti_pkg::*;
   logic [7:0] c_dio = 8'h00;
   logic       c_dav = 0, c_atn = 0, c_eoi = 0, ren = 0, ifc = 0;
   logic       nrfd = 0, ndac = 1, slow = 0;
   logic [8:0] got;
   int         n_got;
   // Wired-OR lines; released data lines rise to the pull-up (false)
   assign bus = '{dio: ~(c_dio | dev.dio_oe), dav: c_dav | dev.dav_oe,
                  nrfd: nrfd | dev.nrfd_oe, ndac: ndac | dev.ndac_oe,
                  atn: c_atn, eoi: c_eoi | dev.eoi_oe, ren: ren, ifc: ifc};
   // listener half of the source handshake, slow mode stretches it
   initial forever
   begin
      @(posedge clk iff dev.dav_oe);
      #1 nrfd = 1'b1;
      got = {bus.eoi, ~bus.dio};
      n_got++;
      repeat (slow ? 40 : 2) @(posedge clk);
      #1 ndac = 1'b0;
      @(posedge clk iff !dev.dav_oe);
      #1 ndac = 1'b1;
      repeat (slow ? 40 : 2) @(posedge clk);
      #1 nrfd = 1'b0;
   end
   // One byte through the device acceptor; waits are bounded for refusals
   task automatic send(input logic [7:0] b, input logic a, input logic e);
      int n;
      @(posedge clk);
      #1 c_atn = a;
      c_eoi = e;
      c_dio = b;
      repeat (3) @(posedge clk);
      #1 c_dav = 1'b1;
      n = 0;
      repeat (4) @(posedge clk);
      while (dev.ndac_oe && n < 40) begin @(posedge clk); n++; end
      #1 c_dav = 1'b0;
      c_dio = 8'h00;
      c_eoi = 1'b0;
      n = 0;
      while (dev.nrfd_oe && n < 40) begin @(posedge clk); n++; end
   endtask
endmodule

// [verilog/gpti_fifo.sv]
// Small register-read FIFO holding outgoing talker words
`timescale 1ns/1ns
module gpti_fifo
   import gpti_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 arst_n,
   input  wire logic                 flush,
   input  wire logic                 wr_en,
   input  gpti_pkg::gpti_word_t      wr_data,
   input  wire logic                 rd_en,
   output gpti_pkg::gpti_word_t      rd_data,
   output logic                      full,
   output logic                      empty
);
   import gpti_pkg::*;

   gpti_word_t                 mem [GPTI_FIFO_DEPTH];
   logic [GPTI_FIFO_AW:0]      wr_ptr_reg;
   logic [GPTI_FIFO_AW:0]      rd_ptr_reg;
   logic [GPTI_FIFO_AW:0]      rd_ptr_next;
   logic [GPTI_FIFO_AW:0]      wr_ptr_dly_reg;

   assign full  = (wr_ptr_reg[GPTI_FIFO_AW] != rd_ptr_next[GPTI_FIFO_AW]) &&
                  (wr_ptr_reg[GPTI_FIFO_AW-1:0] == rd_ptr_next[GPTI_FIFO_AW-1:0]);
   // Lags one write, so the registered head is never stale when shown
   assign empty = (wr_ptr_dly_reg == rd_ptr_reg);
   assign rd_ptr_next = rd_ptr_reg;

   // ==========================================================
   // Storage, no reset needed on data
   always_ff @(posedge clk)
   begin
      if (wr_en && !full)
         mem[wr_ptr_reg[GPTI_FIFO_AW-1:0]] <= wr_data;
   end

   // Registered read data, shows head of queue
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         rd_data <= '0;
      else
         rd_data <= mem[rd_ptr_reg[GPTI_FIFO_AW-1:0] + GPTI_FIFO_AW'(rd_en && !empty)];
   end

   // Pointers; flush empties the queue on device clear
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         wr_ptr_dly_reg <= '0;
      end
      else if (flush)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         wr_ptr_dly_reg <= '0;
      end
      else
      begin
         wr_ptr_dly_reg <= wr_ptr_reg;
         if (wr_en && !full)
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (rd_en && !empty)
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
   end

endmodule

// [verilog/gpti_pkg.sv]
// Package: constants and carrier types for the IEEE-488 talker/listener interface
package gpti_pkg;

   // ==========================================================
   // Addressing
   localparam logic [5:0] GPTI_ADDR_DEFAULT  = 6'h1b;   // 27
   localparam logic [5:0] GPTI_ADDR_MAX      = 6'h1e;   // 30
   localparam logic [5:0] GPTI_ADDR_TO_PFX   = 6'h28;   // 40, talk-only with prefix
   localparam logic [5:0] GPTI_ADDR_TO_NOPFX = 6'h29;   // 41, talk-only without prefix

   // ==========================================================
   // Command byte codes, low seven bits with ATN asserted
   localparam logic [6:0] GPTI_CMD_GTL  = 7'h01;
   localparam logic [6:0] GPTI_CMD_SDC  = 7'h04;
   localparam logic [6:0] GPTI_CMD_GET  = 7'h08;
   localparam logic [6:0] GPTI_CMD_LLO  = 7'h11;
   localparam logic [6:0] GPTI_CMD_DCL  = 7'h14;
   localparam logic [6:0] GPTI_CMD_SPE  = 7'h18;
   localparam logic [6:0] GPTI_CMD_SPD  = 7'h19;
   localparam logic [6:0] GPTI_CMD_UNL  = 7'h3f;
   localparam logic [6:0] GPTI_CMD_UNT  = 7'h5f;
   localparam logic [1:0] GPTI_GRP_LAG  = 2'h1;    // Bits 6:5 of a listen address
   localparam logic [1:0] GPTI_GRP_TAG  = 2'h2;    // Bits 6:5 of a talk address
   localparam logic [1:0] GPTI_GRP_SCG  = 2'h3;    // Secondary group, ignored
   localparam int         GPTI_RQS_BIT  = 6;       // Request-service bit of status byte

   // ==========================================================
   // Timing
   localparam int GPTI_CLK_NS     = 10;
   localparam int GPTI_SETTLE_NS  = 500;   // Data settle before DAV
   localparam int GPTI_SETTLE_CYC = (GPTI_SETTLE_NS + GPTI_CLK_NS - 1) / GPTI_CLK_NS;
   localparam int GPTI_FIFO_DEPTH = 4;
   localparam int GPTI_FIFO_AW    = 2;

   // ==========================================================
   // Carrier types: bus lines seen from the device
   typedef struct packed {
      logic [7:0] dio;
      logic       dav;
      logic       nrfd;
      logic       ndac;
      logic       atn;
      logic       eoi;
      logic       ren;
      logic       ifc;
   } gpti_bus_in_t;

   // Open-collector drives: a set enable pulls the line true
   typedef struct packed {
      logic [7:0] dio_oe;
      logic       dav_oe;
      logic       nrfd_oe;
      logic       ndac_oe;
      logic       eoi_oe;
      logic       srq_oe;
   } gpti_bus_out_t;

   // Data word with end flag
   typedef struct packed {
      logic       last;
      logic [7:0] data;
   } gpti_word_t;

   // Interface state for the instrument
   typedef struct packed {
      logic remote;
      logic lockout;
      logic talker;
      logic listener;
      logic spoll;
      logic talk_only;
      logic prefix;
   } gpti_state_t;

endpackage

// [verilog/gpti_top.sv]
// Device-side IEEE-488 talker/listener interface logic
// Function
// R1: Source handshake drives DAV, awaits listeners
// R2: Acceptor handshake takes each byte once
// R3: Talk only when addressed or talk-only
// R4: Accept data only when listen-addressed
// R5: Talker with serial poll, unaddressed on MLA
// R6: Listener unaddressed on own talk address
// R7: SRQ asserted, reported via status byte
// R8: Remote/local machine with local lockout
// R9: No parallel poll response ever
// R10: DCL or addressed SDC clears device
// R11: GET while listening triggers reading
// R12: Never drives ATN, IFC or REN
// R13: Secondary addresses ignored
// R14: Remote only when listen-addressed with REN
// R15: Controller asserts REN before listen address
// R16: Decode universal, address, addressed commands
// R17: Other talk address or UNT unaddresses talker
// R18: Primary address 0 to 30, default 27
// R19: Setting 40/41 selects talk-only, ignore commands
// R20: ATN bytes compared against own address
`timescale 1ns/1ns
module gpti_top
   import gpti_pkg::*;
(
   input  wire logic                 CLK,
   input  wire logic                 ARST_N,
   input  gpti_pkg::gpti_bus_in_t    BUS_IN,
   output gpti_pkg::gpti_bus_out_t   BUS_OUT,
   input  wire logic [5:0]           ADDR_SET,
   input  wire logic                 ADDR_LOAD,
   input  wire logic                 TX_VALID,
   input  gpti_pkg::gpti_word_t      TX_WORD,
   output logic                      TX_READY,
   output logic                      RX_VALID,
   output gpti_pkg::gpti_word_t      RX_WORD,
   input  wire logic [7:0]           STATUS_BYTE,
   input  wire logic                 SRQ_REQ,
   output logic                      TRIGGER,
   output logic                      DEV_CLEAR,
   output gpti_pkg::gpti_state_t     STATE
);
   import gpti_pkg::*;

   typedef enum {AH_IDLE, AH_READY, AH_ACCEPT} gpti_ah_t;
   typedef enum {SH_IDLE, SH_SETTLE, SH_VALID, SH_WAIT} gpti_sh_t;

   gpti_bus_in_t   sync1_reg;
   gpti_bus_in_t   sync2_reg;
   gpti_ah_t       ah_reg;
   gpti_sh_t       sh_reg;
   logic [5:0]     addr_reg;
   logic [7:0]     byte_reg;
   logic           atn_byte_reg;
   logic           eoi_byte_reg;
   logic           byte_stb_reg;
   logic [7:0]     settle_reg;
   logic [7:0]     src_data_reg;
   logic           src_eoi_reg;
   logic           src_poll_reg;
   logic           srq_reg;
   logic           rqs_pend_reg;
   logic           talker_reg;
   logic           listener_reg;
   logic           spoll_reg;
   logic           remote_reg;
   logic           lockout_reg;
   logic           trigger_reg;
   logic           clear_reg;
   logic           rx_valid_reg;
   gpti_word_t     rx_word_reg;
   logic           tx_ready_reg;
   gpti_bus_out_t  out_reg;
   gpti_word_t     fifo_head;
   logic           fifo_full;
   logic           fifo_empty;
   logic           fifo_pop;
   logic           talk_only;
   logic           ifc;
   logic           cmd_stb;
   logic           my_la;
   logic           my_ta;
   logic           ota;
   logic           may_talk;

   // ==========================================================
   // Input synchroniser, two flops on every bus line
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end
      else
      begin
         sync1_reg <= BUS_IN;
         sync2_reg <= sync1_reg;
      end
   end

   // Address decode helper used for own talk and listen compare
   function automatic logic addr_hit(input logic [6:0] cmd, input logic [1:0] grp,
                                     input logic [5:0] adr);
      addr_hit = (cmd[6:5] == grp) && ({1'b0, cmd[4:0]} == adr);
   endfunction

   // ==========================================================
   // Address setting
   // R18 range and default
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         addr_reg <= GPTI_ADDR_DEFAULT;
      else if (ADDR_LOAD && (ADDR_SET <= GPTI_ADDR_MAX || ADDR_SET == GPTI_ADDR_TO_PFX ||
                             ADDR_SET == GPTI_ADDR_TO_NOPFX))
         addr_reg <= ADDR_SET;
   end

   // R19 talk-only selection
   assign talk_only = (addr_reg == GPTI_ADDR_TO_PFX) || (addr_reg == GPTI_ADDR_TO_NOPFX);
   assign ifc       = sync2_reg.ifc && !talk_only;

   // ==========================================================
   // Acceptor handshake
   // R2 byte taken once per DAV cycle
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         ah_reg       <= AH_IDLE;
         byte_reg     <= '0;
         atn_byte_reg <= 1'b0;
         eoi_byte_reg <= 1'b0;
         byte_stb_reg <= 1'b0;
      end
      else
      begin
         byte_stb_reg <= 1'b0;
         unique case (ah_reg)
            AH_IDLE:
               // Only listeners or ATN traffic are handshaken; talk-only sits out
               if (!sync2_reg.dav && !talk_only && (sync2_reg.atn || listener_reg))
                  ah_reg <= AH_READY;
            AH_READY:
               if (sync2_reg.dav)
               begin
                  byte_reg     <= ~sync2_reg.dio;   // Bus is negative logic
                  atn_byte_reg <= sync2_reg.atn;
                  eoi_byte_reg <= sync2_reg.eoi;
                  byte_stb_reg <= 1'b1;
                  ah_reg       <= AH_ACCEPT;
               end
               else if (!sync2_reg.atn && !listener_reg)
                  ah_reg <= AH_IDLE;
            AH_ACCEPT:
               if (!sync2_reg.dav)
                  ah_reg <= AH_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Command decode
   // R20 ATN bytes are commands
   assign cmd_stb = byte_stb_reg && atn_byte_reg && !talk_only;
   assign my_la   = addr_hit(byte_reg[6:0], GPTI_GRP_LAG, addr_reg);
   assign my_ta   = addr_hit(byte_reg[6:0], GPTI_GRP_TAG, addr_reg);
   // R17 other talk address detection
   assign ota     = (byte_reg[6:5] == GPTI_GRP_TAG) && !my_ta && byte_reg[6:0] != GPTI_CMD_UNT;

   // R16 addressing and universal state
   // R13 secondary group falls through every compare
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         talker_reg   <= 1'b0;
         listener_reg <= 1'b0;
         spoll_reg    <= 1'b0;
      end
      else if (ifc)
      begin
         talker_reg   <= 1'b0;
         listener_reg <= 1'b0;
         spoll_reg    <= 1'b0;
      end
      else if (cmd_stb)
      begin
         // R4 listen address arms data acceptance
         // R5 own listen address leaves talker
         if (my_la)
         begin
            listener_reg <= 1'b1;
            talker_reg   <= 1'b0;
         end
         // R6 own talk address leaves listener
         if (my_ta)
         begin
            talker_reg   <= 1'b1;
            listener_reg <= 1'b0;
         end
         if (byte_reg[6:0] == GPTI_CMD_UNL)
            listener_reg <= 1'b0;
         // R17 untalk or other talker
         if (byte_reg[6:0] == GPTI_CMD_UNT || ota)
            talker_reg <= 1'b0;
         if (byte_reg[6:0] == GPTI_CMD_SPE)
            spoll_reg <= 1'b1;
         if (byte_reg[6:0] == GPTI_CMD_SPD)
            spoll_reg <= 1'b0;
      end
   end

   // R8 remote/local with lockout
   // R14 remote needs listen address under REN
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         remote_reg  <= 1'b0;
         lockout_reg <= 1'b0;
      end
      else if (!sync2_reg.ren || talk_only)
      begin
         remote_reg  <= 1'b0;   // REN false or talk-only cancels lockout
         lockout_reg <= 1'b0;
      end
      else if (ifc)
         remote_reg <= 1'b0;
      else if (cmd_stb)
      begin
         if (my_la)
            remote_reg <= 1'b1;
         else if (byte_reg[6:0] == GPTI_CMD_GTL && listener_reg)
            remote_reg <= 1'b0;
         if (byte_reg[6:0] == GPTI_CMD_LLO)
            lockout_reg <= 1'b1;
      end
   end

   // R10 clear and R11 trigger pulses
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         trigger_reg <= 1'b0;
         clear_reg   <= 1'b0;
      end
      else
      begin
         trigger_reg <= cmd_stb && listener_reg && byte_reg[6:0] == GPTI_CMD_GET;
         clear_reg   <= cmd_stb && (byte_reg[6:0] == GPTI_CMD_DCL ||
                        (listener_reg && byte_reg[6:0] == GPTI_CMD_SDC));
      end
   end

   // R4 data bytes delivered only while listening
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         rx_valid_reg <= 1'b0;
         rx_word_reg  <= '0;
      end
      else
      begin
         rx_valid_reg <= byte_stb_reg && !atn_byte_reg && listener_reg;
         if (byte_stb_reg && !atn_byte_reg)
            rx_word_reg <= '{last: eoi_byte_reg, data: byte_reg};
      end
   end

   // ==========================================================
   // Service request
   // R7 SRQ until polled, RQS in status
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         srq_reg      <= 1'b0;
         rqs_pend_reg <= 1'b0;
      end
      else if (clear_reg || ifc)
      begin
         srq_reg      <= 1'b0;
         rqs_pend_reg <= 1'b0;
      end
      else if (sh_reg == SH_WAIT && src_poll_reg && !sync2_reg.ndac)
      begin
         srq_reg      <= 1'b0;   // Status byte with RQS accepted; new request wins next
         rqs_pend_reg <= 1'b0;
      end
      else if (SRQ_REQ && !talk_only)
      begin
         srq_reg      <= 1'b1;
         rqs_pend_reg <= 1'b1;
      end
   end

   // ==========================================================
   // Source handshake
   // R3 sourcing only when addressed or talk-only
   assign may_talk = (talker_reg || talk_only) && !sync2_reg.atn;
   assign fifo_pop = sh_reg == SH_IDLE && may_talk && !spoll_reg && !fifo_empty;

   gpti_fifo u_fifo
   (
      .clk     (CLK),
      .arst_n  (ARST_N),
      .flush   (clear_reg),
      .wr_en   (TX_VALID),
      .wr_data (TX_WORD),
      .rd_en   (fifo_pop),
      .rd_data (fifo_head),
      .full    (fifo_full),
      .empty   (fifo_empty)
   );

   // R1 DAV after settle, wait RFD then DAC
   // R5 serial poll sources status byte
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         sh_reg       <= SH_IDLE;
         settle_reg   <= '0;
         src_data_reg <= '0;
         src_eoi_reg  <= 1'b0;
         src_poll_reg <= 1'b0;
      end
      else if (!may_talk || clear_reg)
         sh_reg <= SH_IDLE;   // ATN or unaddressing aborts a byte in flight
      else
      begin
         unique case (sh_reg)
            SH_IDLE:
               if (spoll_reg || !fifo_empty)
               begin
                  src_poll_reg <= spoll_reg;
                  src_data_reg <= spoll_reg ? {STATUS_BYTE[7], rqs_pend_reg,
                                  STATUS_BYTE[5:0]} : fifo_head.data;
                  src_eoi_reg  <= spoll_reg ? 1'b0 : fifo_head.last;
                  settle_reg   <= 8'(GPTI_SETTLE_CYC);
                  sh_reg       <= SH_SETTLE;
               end
            SH_SETTLE:
               if (settle_reg != 8'h00)
                  settle_reg <= settle_reg - 8'h01;
               else if (!sync2_reg.nrfd)
                  sh_reg <= SH_VALID;
            SH_VALID:
               sh_reg <= SH_WAIT;
            SH_WAIT:
               if (!sync2_reg.ndac)
                  sh_reg <= SH_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Registered bus drivers
   // R9 no parallel poll; R12 no controller lines
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         out_reg <= '0;
      else
      begin
         out_reg.dio_oe  <= (sh_reg != SH_IDLE && may_talk) ? src_data_reg : 8'h00;
         out_reg.eoi_oe  <= sh_reg != SH_IDLE && may_talk && src_eoi_reg;
         out_reg.dav_oe  <= (sh_reg == SH_VALID || sh_reg == SH_WAIT) && may_talk;
         out_reg.nrfd_oe <= ah_reg != AH_READY && (ah_reg != AH_IDLE ||
                            sync2_reg.atn || listener_reg) && !talk_only;
         out_reg.ndac_oe <= ah_reg != AH_ACCEPT && (sync2_reg.atn || listener_reg) &&
                            !talk_only;
         out_reg.srq_oe  <= srq_reg;
      end
   end

   // Outputs to the instrument side
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         tx_ready_reg <= 1'b0;
         STATE        <= '0;
      end
      else
      begin
         tx_ready_reg <= !fifo_full && !TX_VALID;
         STATE        <= '{remote: remote_reg, lockout: lockout_reg, talker: talker_reg,
                           listener: listener_reg, spoll: spoll_reg, talk_only: talk_only,
                           prefix: addr_reg == GPTI_ADDR_TO_PFX};
      end
   end

   assign BUS_OUT   = out_reg;
   assign TX_READY  = tx_ready_reg;
   assign RX_VALID  = rx_valid_reg;
   assign RX_WORD   = rx_word_reg;
   assign TRIGGER   = trigger_reg;
   assign DEV_CLEAR = clear_reg;

endmodule
